// ---- include/tbo_pkg.sv ----
// package for the 10 Mb/s operations register block
package tbo_pkg;
  localparam int unsigned REG_W          = 16;
  localparam logic [4:0]  REG_ADDR       = 5'h12;
  localparam int unsigned BIT_RJAB       = 15;
  localparam int unsigned BIT_POLREV     = 14;
  localparam int unsigned BIT_JAB_INH    = 5;
  localparam int unsigned BIT_RSVD_ONE   = 4;
  localparam int unsigned BIT_APOL_INH   = 3;
  localparam int unsigned BIT_SQE_INH    = 2;
  localparam int unsigned BIT_LINK_INH   = 1;
  localparam int unsigned BIT_SQL_INH    = 0;
  localparam logic [4:0]  CTRL_RESET     = 5'h00;
  // sqe test pulse timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned SQE_DELAY_NS   = 1000;
  localparam int unsigned SQE_WIDTH_NS   = 1000;
  localparam int unsigned SQE_DELAY_CYC  = (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SQE_WIDTH_CYC  = (SQE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SQE_CNT_W      = 10;

  // controls handed to the 10 Mb/s transmit and receive logic
  typedef struct packed {
    logic jabber_check_en;
    logic auto_polarity_en;
    logic sqe_test_en;
    logic link_force_pass;
    logic squelch_need_idle;
  } tbo_ctrl_t;

  // events from the 10 Mb/s logic
  typedef struct packed {
    logic remote_jabber;
    logic polarity_reversed;
  } tbo_evt_t;

  typedef enum logic [1:0] {
    SQE_IDLE  = 2'b00,
    SQE_WAIT  = 2'b01,
    SQE_PULSE = 2'b11
  } tbo_sqe_state_t;
endpackage

// ---- hw/tbo_sync.sv ----
// three-flop synchroniser with agreement filter for pin-side inputs
`timescale 1ns/1ps
module tbo_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit moves only once the second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        q_o[i] <= 1'b0;
      end else if (s2_reg[i] == s3_reg[i]) begin
        q_o[i] <= s3_reg[i];
      end
    end
  end
endmodule

// ---- hw/tbo_regs.sv ----
// 10 Mb/s operations control and status register with sqe test pulse
//
// What this block does
// - bit 15 latches remote jabber seen on receive; read or reset clears it.
// - remote jabber only sets the status bit, no other port action.
// - bit 14 latches high when receive pair polarity is reversed.
// - operation continues normally regardless of receive polarity.
// - bit 5 set disables jabber checking during transmit; reset zero.
// - bit 3 set inhibits automatic receive polarity correction; reset zero.
// - bit 2 set disables sqe test generation; reset zero.
// - with sqe test enabled, pulse collision briefly after transmit enable falls.
// - sqe pulse suppressed in full duplex and repeater mode.
// - sqe inhibit bit reads back only what was written.
// - bit 1 set forces link integrity machine into link pass.
// - bit 0 set needs valid data then idle before link comes up.
`timescale 1ns/1ps
module tbo_regs
  import tbo_pkg::*;
#(
  parameter int unsigned SQE_DELAY = SQE_DELAY_CYC,
  parameter int unsigned SQE_WIDTH = SQE_WIDTH_CYC
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // management register access
  input  wire logic [4:0]          reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [REG_W-1:0]    reg_wdata_i,
  output logic      [REG_W-1:0]    reg_rdata_o,
  output logic                     reg_rvalid_o,
  // 10 Mb/s logic side
  input  wire tbo_pkg::tbo_evt_t   evt_i,
  input  wire logic                tx_en_i,
  input  wire logic                full_duplex_i,
  input  wire logic                repeater_i,
  output tbo_pkg::tbo_ctrl_t       ctrl_o,
  output logic                     sqe_col_o
);
  import tbo_pkg::*;

  logic [4:0]         ctrl_reg;
  logic               rjab_reg;
  logic               polrev_reg;
  tbo_evt_t           evt_s;
  logic               tx_en_d_reg;
  tbo_sqe_state_t     sqe_reg;
  logic [SQE_CNT_W-1:0] cnt_reg;
  logic               hit_rd;
  logic               hit_wr;

  // event pins come from another clock region
  tbo_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (evt_i),
    .q_o   (evt_s)
  );

  assign hit_rd = reg_rd_i && (reg_addr_i == REG_ADDR);
  assign hit_wr = reg_wr_i && (reg_addr_i == REG_ADDR);

  // control bits; reserved bits are not stored, manager must write defaults
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (hit_wr) begin
      ctrl_reg <= {reg_wdata_i[BIT_JAB_INH], reg_wdata_i[BIT_APOL_INH],
                   reg_wdata_i[BIT_SQE_INH], reg_wdata_i[BIT_LINK_INH],
                   reg_wdata_i[BIT_SQL_INH]};
    end
  end

  // latching-high status; set wins over the read clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rjab_reg   <= 1'b0;
      polrev_reg <= 1'b0;
    end else begin
      rjab_reg   <= evt_s.remote_jabber | (rjab_reg & ~hit_rd);
      polrev_reg <= evt_s.polarity_reversed | (polrev_reg & ~hit_rd);
    end
  end

  // read data registered; clear and capture happen on the same edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o  <= '0;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= hit_rd;
      if (hit_rd) begin
        reg_rdata_o               <= '0;
        reg_rdata_o[BIT_RJAB]     <= rjab_reg;
        reg_rdata_o[BIT_POLREV]   <= polrev_reg;
        reg_rdata_o[BIT_JAB_INH]  <= ctrl_reg[4];
        reg_rdata_o[BIT_RSVD_ONE] <= 1'b1;
        reg_rdata_o[BIT_APOL_INH] <= ctrl_reg[3];
        reg_rdata_o[BIT_SQE_INH]  <= ctrl_reg[2];
        reg_rdata_o[BIT_LINK_INH] <= ctrl_reg[1];
        reg_rdata_o[BIT_SQL_INH]  <= ctrl_reg[0];
      end
    end
  end

  // controls out; polarity enable goes only to the 10 Mb/s logic and never stops traffic
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_o <= '{jabber_check_en: 1'b1, auto_polarity_en: 1'b1, sqe_test_en: 1'b1,
                  link_force_pass: 1'b0, squelch_need_idle: 1'b0};
    end else begin
      ctrl_o.jabber_check_en   <= ~ctrl_reg[4];
      ctrl_o.auto_polarity_en  <= ~ctrl_reg[3];
      ctrl_o.sqe_test_en       <= ~ctrl_reg[2] & ~full_duplex_i & ~repeater_i;
      ctrl_o.link_force_pass   <= ctrl_reg[1];
      ctrl_o.squelch_need_idle <= ctrl_reg[0];
    end
  end

  // tx_en is same-clock logic, no synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_en_d_reg <= 1'b0;
    end else begin
      tx_en_d_reg <= tx_en_i;
    end
  end

  // sqe test: wait after transmit end, then hold collision for the width
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sqe_reg   <= SQE_IDLE;
      cnt_reg   <= '0;
      sqe_col_o <= 1'b0;
    end else begin
      unique case (sqe_reg)
        SQE_IDLE: begin
          sqe_col_o <= 1'b0;
          if (tx_en_d_reg && !tx_en_i && !ctrl_reg[2] && !full_duplex_i && !repeater_i) begin
            sqe_reg <= SQE_WAIT;
            cnt_reg <= SQE_CNT_W'(SQE_DELAY - 1);
          end
        end
        SQE_WAIT: begin
          if (tx_en_i || full_duplex_i || repeater_i) begin
            sqe_reg <= SQE_IDLE;
          end else if (cnt_reg == '0) begin
            sqe_reg   <= SQE_PULSE;
            sqe_col_o <= 1'b1;
            cnt_reg   <= SQE_CNT_W'(SQE_WIDTH - 1);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        SQE_PULSE: begin
          if (cnt_reg == '0 || full_duplex_i || repeater_i) begin
            sqe_reg   <= SQE_IDLE;
            sqe_col_o <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          sqe_reg   <= SQE_IDLE;
          sqe_col_o <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- bench/tbo_chk.sv ----
// assertion checker for the 10 Mb/s operations register
`timescale 1ns/1ps
module tbo_chk
  import tbo_pkg::*;
#(parameter int unsigned SQE_DELAY = SQE_DELAY_CYC, parameter int unsigned SQE_WIDTH = SQE_WIDTH_CYC) (
  input wire logic clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, tx_en_i, full_duplex_i, repeater_i, sqe_col_o,
  input wire logic [4:0]       reg_addr_i,
  input wire logic [REG_W-1:0] reg_wdata_i, reg_rdata_o,
  input wire tbo_evt_t         evt_i,
  input wire tbo_ctrl_t        ctrl_o
);
  // pulse is sampled high one edge after the wait counter runs out
  localparam int SQE_AT = SQE_DELAY + 1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire w = reg_wr_i && reg_addr_i == REG_ADDR;
  AST_RD: assert property (reg_rvalid_o |-> $past(reg_rd_i && reg_addr_i == REG_ADDR))
    else $error("answer without a read");
  AST_RSV: assert property (reg_rvalid_o |-> reg_rdata_o[13:6] == 8'h00 && reg_rdata_o[4])
    else $error("reserved bits read wrong");
  AST_JAB: assert property (w && reg_wdata_i[5] |-> ##2 !ctrl_o.jabber_check_en)
    else $error("jabber check not off");
  AST_APOL: assert property (w && !reg_wdata_i[3] |-> ##2 ctrl_o.auto_polarity_en)
    else $error("polarity correction off");
  AST_LINK: assert property (w && reg_wdata_i[1] |-> ##2 ctrl_o.link_force_pass)
    else $error("link not forced");
  AST_FDX: assert property (full_duplex_i || repeater_i |=> !ctrl_o.sqe_test_en)
    else $error("sqe enabled in duplex or repeater");
  AST_SQE: assert property ($fell(tx_en_i) && ctrl_o.sqe_test_en && !full_duplex_i && !repeater_i |-> ##[1:SQE_AT] sqe_col_o)
    else $error("no sqe pulse");
  AST_QUIET: assert property ((full_duplex_i || repeater_i) [*3] |-> !sqe_col_o)
    else $error("sqe pulse in duplex or repeater");
endmodule
bind tbo_regs tbo_chk #(.SQE_DELAY(SQE_DELAY), .SQE_WIDTH(SQE_WIDTH)) u_chk (.*);

// ---- bench/tbo_far.sv ----
// far-side model: 10 Mb/s logic raising events and sending frames
`timescale 1ns/1ps
module tbo_far
  import tbo_pkg::*;
(
  input  wire logic        clk_i,
  output tbo_pkg::tbo_evt_t evt_o,
  output logic             tx_en_o
);
  initial begin
    evt_o = '0;
    tx_en_o = 1'b0;
  end
  // the frame end lands on an edge; the sqe wait starts on the next edge
  task automatic send(input int n);
    @(posedge clk_i) tx_en_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    tx_en_o <= 1'b0;
  endtask
  task automatic event_set(input logic [1:0] v);
    @(posedge clk_i) evt_o <= v;
  endtask
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the 10 Mb/s operations register
`timescale 1ns/1ps
module tb;
  import tbo_pkg::*;
  logic clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, full_duplex_i = 0, repeater_i = 0;
  logic tx_en_i, reg_rvalid_o, sqe_col_o;
  logic [4:0]  reg_addr_i = REG_ADDR;
  logic [15:0] reg_wdata_i = '0, reg_rdata_o, d;
  tbo_evt_t    evt_i;
  tbo_ctrl_t   ctrl_o;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  initial forever #2.5 clk_i = ~clk_i;
  tbo_far far (.clk_i(clk_i), .evt_o(evt_i), .tx_en_o(tx_en_i));
  tbo_regs #(.SQE_DELAY(2), .SQE_WIDTH(3)) uut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .evt_i(evt_i), .tx_en_i(tx_en_i), .full_duplex_i(full_duplex_i),
    .repeater_i(repeater_i), .ctrl_o(ctrl_o), .sqe_col_o(sqe_col_o));
  task automatic report_and_stop();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // ctrl_o is settled one edge after the write is taken
  task automatic wr(input logic [15:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= REG_ADDR;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rvalid_o === (a == REG_ADDR), "rvalid");
    if (a == REG_ADDR) chk(reg_rdata_o === e, "rdata");
  endtask
  task automatic sqe(input int w);
    int n = 0;
    far.send(4);
    repeat (20) begin
      @(posedge clk_i);
      #1;
      if (sqe_col_o === 1'b1) n++;
    end
    chk(n == w, "sqe width");
  endtask
  task automatic ev(input logic [1:0] v);
    far.event_set(v);
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(ctrl_o === 5'b11100, "reset ctrl");
    rd(REG_ADDR, 16'h0010);
    rd(5'h13, 16'h0000);
    ev(2'b10);
    ev(2'b00);
    rd(REG_ADDR, 16'h8010);
    chk(ctrl_o === 5'b11100, "ctrl moved");
    rd(REG_ADDR, 16'h0010);
    ev(2'b01);
    rd(REG_ADDR, 16'h4010);
    rd(REG_ADDR, 16'h4010);
    ev(2'b00);
    rd(REG_ADDR, 16'h4010);
    rd(REG_ADDR, 16'h0010);
    for (int i = 0; i < 6; i++) begin
      d = 16'h0010 | (16'h0001 << i);
      wr(d);
      chk(ctrl_o === {~d[5], ~d[3], ~d[2], d[1], d[0]}, "ctrl");
      rd(REG_ADDR, d);
    end
    wr(16'h0010);
    sqe(3);
    @(posedge clk_i);
    full_duplex_i <= 1'b1;
    sqe(0);
    rd(REG_ADDR, 16'h0010);
    full_duplex_i <= 1'b0;
    repeater_i <= 1'b1;
    sqe(0);
    repeater_i <= 1'b0;
    wr(16'h0014);
    sqe(0);
    report_and_stop();
  end
endmodule
